// [hw/scan_cfg.svh]
// constants for the boundary-scan test logic
// assumes inclusion by the scan package, the block and its bench
`ifndef SCAN_CFG_SVH
`define SCAN_CFG_SVH
`define IR_WIDTH          4
`define IR_CAPTURE        4'h1
`define OP_EXTEST         4'h0
`define OP_IDCODE         4'h1
`define OP_SNAPSHOT       4'h2
`define OP_CORE_RESET     4'hC
`define OP_BYPASS         4'hF
`define NUM_PINS          8
`define PIN_IDX_SCL       0
`define PIN_IDX_SDA       1
`define NUM_OSC           5
`define OSC_IDX_LOWFREQ   3
`define OSC_UNUSED_LEVEL  5'h08
`define ADDR_WIDTH        8
`define ADDR_MCU_CS       8'h34
`define BIT_PORT_DISABLE  7
`define BIT_TEST_RESET    4
`define LOCK_WINDOW       3'h4
`define MCU_CS_RESET      8'h00
`define IDCODE_VALUE      32'h0000_0001 // arbitrary neutral value, names no maker or part
`endif

// [hw/scan_pkg.sv]
// types shared by the boundary-scan test logic
// assumes the constant header is on the include path
`include "scan_cfg.svh"
package scan_pkg;
   typedef enum logic [3:0] {
      TEST_LOGIC_RESET = 4'h0,
      RUN_IDLE         = 4'h1,
      SELECT_DR        = 4'h3,
      CAPTURE_DR       = 4'h2,
      SHIFT_DR         = 4'h6,
      EXIT1_DR         = 4'h7,
      PAUSE_DR         = 4'h5,
      EXIT2_DR         = 4'h4,
      UPDATE_DR        = 4'hC,
      SELECT_IR        = 4'hD,
      CAPTURE_IR       = 4'hF,
      SHIFT_IR         = 4'hE,
      EXIT1_IR         = 4'hA,
      PAUSE_IR         = 4'hB,
      EXIT2_IR         = 4'h9,
      UPDATE_IR        = 4'h8
   } tap_state_type;
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } tap_in_type;
   typedef struct packed {
      logic [`NUM_PINS-1:0] direction_bit;
      logic [`NUM_PINS-1:0] port_output_bit;
      logic                 global_pullup_disable;
      logic [1:0]           two_wire_drive_enable;
   } core_pins_type;
endpackage : scan_pkg

// [hw/boundary_scan_chain_logic.sv]
// boundary-scan test logic: tap controller, instruction and data registers,
// scan cells for port pins, two-wire enables, reset pin and oscillators,
// and the control/status register on an apb slave.
// assumes: tck/tms/tdi arrive asynchronously and are sampled on CLOCK,
// which must run at least several times faster than the test clock.
`timescale 1ns/1ps
`include "scan_cfg.svh"
module boundary_scan_chain_logic (
   input  wire logic                  CLOCK,
   input  wire logic                  RST,
   input  wire logic                  BROWN_OUT_RESET,
   input  wire scan_pkg::tap_in_type  TAP_IN,
   output logic                       TDO,
   output logic                       TDO_OE_N,
   input  wire logic                  TEST_PORT_FUSE,
   input  wire logic [`NUM_PINS-1:0]  PIN_IN,
   input  wire scan_pkg::core_pins_type CORE_PINS,
   input  wire logic                  LOW_VOLTAGE_RESET_N,
   input  wire logic                  HIGH_VOLTAGE_RESET,
   input  wire logic [`NUM_OSC-1:0]   OSC_ENABLE,
   input  wire logic [`NUM_OSC-1:0]   OSC_CLOCK,
   output logic                       CORE_RESET,
   output logic                       TEST_RESET_EVENT,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [`ADDR_WIDTH-1:0] PADDR,
   input  wire logic [31:0]           PWDATA,
   output logic [31:0]                PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR
);
   // chain order from tdo: per pin {pullup, ctl, data}, two-wire enables,
   // reset observe pair, per oscillator {enable, clock}
   localparam int CHAIN_LEN = 3*`NUM_PINS + 2 + 2 + 2*`NUM_OSC;

   // ----------------------------------------------------------------
   // test pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] sync_c;
   logic [2:0] tap_lvl;
   logic       tck_prev;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
         sync_c <= 3'h0;
      end else begin
         sync_a <= {TAP_IN.tck, TAP_IN.tms, TAP_IN.tdi};
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end
   // a change counts only once the second and third stages agree
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tap_lvl <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (sync_b[i] == sync_c[i]) begin
               tap_lvl[i] <= sync_c[i];
            end
         end
      end
   end
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tck_prev <= 1'b0;
      end else begin
         tck_prev <= tap_lvl[2];
      end
   end

   logic port_on;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   assign tms      = tap_lvl[1];
   assign tdi      = tap_lvl[0];
   assign tck_rise = port_on & tap_lvl[2] & ~tck_prev;
   assign tck_fall = port_on & ~tap_lvl[2] & tck_prev;

   // ----------------------------------------------------------------
   // tap state machine
   // ----------------------------------------------------------------
   scan_pkg::tap_state_type state;
   scan_pkg::tap_state_type next_state;
   always_comb begin
      case (state)
         scan_pkg::TEST_LOGIC_RESET: next_state = tms ? scan_pkg::TEST_LOGIC_RESET : scan_pkg::RUN_IDLE;
         scan_pkg::RUN_IDLE:   next_state = tms ? scan_pkg::SELECT_DR : scan_pkg::RUN_IDLE;
         scan_pkg::SELECT_DR:  next_state = tms ? scan_pkg::SELECT_IR : scan_pkg::CAPTURE_DR;
         scan_pkg::CAPTURE_DR: next_state = tms ? scan_pkg::EXIT1_DR : scan_pkg::SHIFT_DR;
         scan_pkg::SHIFT_DR:   next_state = tms ? scan_pkg::EXIT1_DR : scan_pkg::SHIFT_DR;
         scan_pkg::EXIT1_DR:   next_state = tms ? scan_pkg::UPDATE_DR : scan_pkg::PAUSE_DR;
         scan_pkg::PAUSE_DR:   next_state = tms ? scan_pkg::EXIT2_DR : scan_pkg::PAUSE_DR;
         scan_pkg::EXIT2_DR:   next_state = tms ? scan_pkg::UPDATE_DR : scan_pkg::SHIFT_DR;
         scan_pkg::UPDATE_DR:  next_state = tms ? scan_pkg::SELECT_DR : scan_pkg::RUN_IDLE;
         scan_pkg::SELECT_IR:  next_state = tms ? scan_pkg::TEST_LOGIC_RESET : scan_pkg::CAPTURE_IR;
         scan_pkg::CAPTURE_IR: next_state = tms ? scan_pkg::EXIT1_IR : scan_pkg::SHIFT_IR;
         scan_pkg::SHIFT_IR:   next_state = tms ? scan_pkg::EXIT1_IR : scan_pkg::SHIFT_IR;
         scan_pkg::EXIT1_IR:   next_state = tms ? scan_pkg::UPDATE_IR : scan_pkg::PAUSE_IR;
         scan_pkg::PAUSE_IR:   next_state = tms ? scan_pkg::EXIT2_IR : scan_pkg::PAUSE_IR;
         scan_pkg::EXIT2_IR:   next_state = tms ? scan_pkg::UPDATE_IR : scan_pkg::SHIFT_IR;
         scan_pkg::UPDATE_IR:  next_state = tms ? scan_pkg::SELECT_DR : scan_pkg::RUN_IDLE;
         default:              next_state = scan_pkg::TEST_LOGIC_RESET;
      endcase
   end
   // the reset instruction never touches this machine, only RST and a disabled port do
   always_ff @(posedge CLOCK) begin
      if (RST || !port_on) begin
         state <= scan_pkg::TEST_LOGIC_RESET;
      end else if (tck_rise) begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------
   logic [`IR_WIDTH-1:0] ir_shift;
   logic [`IR_WIDTH-1:0] ir;
   always_ff @(posedge CLOCK) begin
      if (RST || state == scan_pkg::TEST_LOGIC_RESET) begin
         ir_shift <= `OP_IDCODE;
         ir       <= `OP_IDCODE;
      end else if (tck_rise) begin
         if (state == scan_pkg::CAPTURE_IR) begin
            ir_shift <= `IR_CAPTURE;
         end else if (state == scan_pkg::SHIFT_IR) begin
            ir_shift <= {tdi, ir_shift[`IR_WIDTH-1:1]};
         end
      end else if (tck_fall && state == scan_pkg::UPDATE_IR) begin
         ir <= ir_shift;
      end
   end

   logic sel_chain;
   logic sel_reset;
   logic sel_id;
   assign sel_chain = (ir == `OP_SNAPSHOT) || (ir == `OP_EXTEST);
   assign sel_reset = (ir == `OP_CORE_RESET);
   assign sel_id    = (ir == `OP_IDCODE);

   // ----------------------------------------------------------------
   // data registers
   // ----------------------------------------------------------------
   logic                  bypass_stage;
   logic                  reset_stage;
   logic [31:0]           id_shift;
   logic [CHAIN_LEN-1:0]  chain;
   logic [CHAIN_LEN-1:0]  latch;
   logic [CHAIN_LEN-1:0]  capture;
   logic [`NUM_OSC-1:0]   osc_clock_seen;
   // idle clock levels and register reset value as vectors, so single bits can be picked
   localparam logic [`NUM_OSC-1:0] OSC_IDLE = `OSC_UNUSED_LEVEL;
   localparam logic [7:0]          CS_RESET = `MCU_CS_RESET;

   // ----------------------------------------------------------------
   // scan cell capture
   // ----------------------------------------------------------------
   // pins observed directly, no synchroniser, alternate functions sit beyond
   // analog paths run pin-to-analog outside this logic, so nothing here sits on them
   always_comb begin
      capture = '0;
      for (int p = 0; p < `NUM_PINS; p++) begin
         capture[3*p]   = ~CORE_PINS.global_pullup_disable & ~CORE_PINS.direction_bit[p]
                          & CORE_PINS.port_output_bit[p];
         capture[3*p+1] = CORE_PINS.direction_bit[p];
         capture[3*p+2] = PIN_IN[p];
      end
      capture[3*`NUM_PINS +: 2]   = CORE_PINS.two_wire_drive_enable;
      capture[3*`NUM_PINS+2]      = ~LOW_VOLTAGE_RESET_N;
      capture[3*`NUM_PINS+3]      = HIGH_VOLTAGE_RESET;
      for (int o = 0; o < `NUM_OSC; o++) begin
         capture[3*`NUM_PINS+4+2*o]   = OSC_ENABLE[o];
         capture[3*`NUM_PINS+5+2*o]   = osc_clock_seen[o];
      end
   end
   // disabled oscillators show their idle level, lowfreq idles high
   always_comb begin
      for (int o = 0; o < `NUM_OSC; o++) begin
         osc_clock_seen[o] = OSC_ENABLE[o] ? OSC_CLOCK[o] : OSC_IDLE[o];
      end
   end
   // load capacitor fuse deliberately has no cell here

   // ----------------------------------------------------------------
   // bypass, reset and id registers
   // ----------------------------------------------------------------
   // opcodes outside the decoded set land in bypass, so stray codes stay harmless

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         bypass_stage <= 1'b0;
      end else if (tck_rise && !sel_chain && !sel_reset && !sel_id) begin
         if (state == scan_pkg::CAPTURE_DR) begin
            bypass_stage <= 1'b0;
         end else if (state == scan_pkg::SHIFT_DR) begin
            bypass_stage <= tdi;
         end
      end
   end

   // no capture on purpose: reset holds until shifted out
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         reset_stage <= 1'b0;
      end else if (tck_rise && sel_reset && state == scan_pkg::SHIFT_DR) begin
         reset_stage <= tdi;
      end
   end
   assign CORE_RESET = reset_stage;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         id_shift <= '0;
      end else if (tck_rise && sel_id) begin
         if (state == scan_pkg::CAPTURE_DR) begin
            id_shift <= `IDCODE_VALUE;       // arbitrary value
         end else if (state == scan_pkg::SHIFT_DR) begin
            id_shift <= {tdi, id_shift[31:1]};
         end
      end
   end

   // ----------------------------------------------------------------
   // boundary chain and update latches
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         chain <= '0;
      end else if (tck_rise && sel_chain) begin
         if (state == scan_pkg::CAPTURE_DR) begin
            chain <= capture;
         end else if (state == scan_pkg::SHIFT_DR) begin
            chain <= {tdi, chain[CHAIN_LEN-1:1]};
         end
      end
   end
   // latches are kept for a later drive stage; this block never routes them to pins
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         latch <= '0;
      end else if (tck_fall && sel_chain && state == scan_pkg::UPDATE_DR) begin
         latch <= chain;
      end
   end

   // ----------------------------------------------------------------
   // test data out, changes on the falling test clock
   // ----------------------------------------------------------------
   logic tdo_bit;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tdo_bit  <= 1'b0;
         TDO_OE_N <= 1'b1;
      end else if (tck_fall) begin
         TDO_OE_N <= ~(state == scan_pkg::SHIFT_DR || state == scan_pkg::SHIFT_IR);
         if (state == scan_pkg::SHIFT_IR) begin
            tdo_bit <= ir_shift[0];
         end else if (sel_chain) begin
            tdo_bit <= chain[0];
         end else if (sel_reset) begin
            tdo_bit <= reset_stage;
         end else if (sel_id) begin
            tdo_bit <= id_shift[0];
         end else begin
            tdo_bit <= bypass_stage;
         end
      end else if (!port_on) begin
         TDO_OE_N <= 1'b1;
      end
   end
   assign TDO = tdo_bit;

   // ----------------------------------------------------------------
   // control/status register over apb
   // ----------------------------------------------------------------
   logic       port_disable;
   logic       test_reset_flag;
   logic       pending_val;
   logic [2:0] window;
   logic       hit;
   logic       wr;
   assign hit  = (PADDR == `ADDR_MCU_CS);
   assign wr   = PSEL & PENABLE & PWRITE & hit;
   assign port_on = TEST_PORT_FUSE & ~port_disable;

   // ----------------------------------------------------------------
   // disable bit timed write
   // ----------------------------------------------------------------
   // a first write opens a four-cycle window; a matching second write commits
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         port_disable <= CS_RESET[`BIT_PORT_DISABLE];
         pending_val  <= 1'b0;
         window       <= 3'h0;
      end else if (wr) begin
         if (window != 3'h0 && PWDATA[`BIT_PORT_DISABLE] == pending_val) begin
            port_disable <= pending_val;
            window       <= 3'h0;
         end else begin
            pending_val <= PWDATA[`BIT_PORT_DISABLE];
            window      <= `LOCK_WINDOW;
         end
      end else if (window != 3'h0) begin
         window <= window - 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // test reset flag
   // ----------------------------------------------------------------
   // set wins over a clearing write; RST is not brown-out so the flag survives it
   always_ff @(posedge CLOCK) begin
      if (BROWN_OUT_RESET) begin
         test_reset_flag <= 1'b0;
      end else if (reset_stage) begin
         test_reset_flag <= 1'b1;
      end else if (wr && !PWDATA[`BIT_TEST_RESET]) begin
         test_reset_flag <= 1'b0;
      end
   end
   assign TEST_RESET_EVENT = reset_stage;

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // loaded in the setup cycle so the access phase answers with no wait state
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         PRDATA <= 32'h0000_0000;
      end else if (PSEL && !PENABLE && !PWRITE && hit) begin
         PRDATA <= 32'h0000_0000 | ({31'h0, port_disable} << `BIT_PORT_DISABLE)
                   | ({31'h0, test_reset_flag} << `BIT_TEST_RESET);
      end else if (PSEL && !PENABLE) begin
         PRDATA <= 32'h0000_0000;
      end
   end
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~hit;
endmodule : boundary_scan_chain_logic

// [tb/scan_monitor.sv]
// port assertions for the boundary-scan block
// assumes binding to the top module; constants come from the shared header
`timescale 1ns/1ps
`include "scan_cfg.svh"
module scan_monitor (
   input wire logic                    CLOCK,
   input wire logic                    RST,
   input wire logic                    BROWN_OUT_RESET,
   input wire logic                    TDO_OE_N,
   input wire logic                    TEST_PORT_FUSE,
   input wire logic                    CORE_RESET,
   input wire logic                    TEST_RESET_EVENT,
   input wire logic                    PSEL,
   input wire logic                    PENABLE,
   input wire logic                    PWRITE,
   input wire logic [`ADDR_WIDTH-1:0]  PADDR,
   input wire logic [31:0]             PRDATA,
   input wire logic                    PREADY,
   input wire logic                    PSLVERR
);
   // -------------------------------------------
   // checks
   // -------------------------------------------
   default clocking mon_clk @(posedge CLOCK); endclocking
   default disable iff (RST);
   wire rd_setup = PSEL && !PENABLE && !PWRITE;
   wire status = PADDR == `ADDR_MCU_CS;
   AST_PREADY: assert property (PSEL && PENABLE |-> PREADY)
      else $error("access not answered at once");
   AST_SLVERR: assert property (PSEL && PENABLE |-> PSLVERR == !status)
      else $error("error response wrong for address");
   AST_UNMAPPED_ZERO: assert property (rd_setup && !status |=> PRDATA == 32'h0)
      else $error("unmapped read returned data");
   AST_RESERVED_ZERO: assert property (PSEL && PENABLE |-> PRDATA[31:8] == 24'h0 && PRDATA[6:5] == 2'h0)
      else $error("reserved status bits not zero");
   AST_EVENT_FOLLOWS: assert property (TEST_RESET_EVENT == CORE_RESET)
      else $error("reset event differs from core reset");
   AST_RELEASE_STATE: assert property ($fell(RST) |-> TDO_OE_N && !CORE_RESET && PRDATA == 32'h0)
      else $error("outputs not idle after reset");
   AST_PORT_OFF: assert property (!TEST_PORT_FUSE [*3] |-> TDO_OE_N)
      else $error("data out enabled with fuse clear");
   AST_FLAG_SETS: assert property (rd_setup && status && CORE_RESET && $past(CORE_RESET) |=> PRDATA[4])
      else $error("flag clear while core reset held");
   AST_FLAG_CLEARS: assert property (rd_setup && status && BROWN_OUT_RESET && $past(BROWN_OUT_RESET)
      && !CORE_RESET && !$past(CORE_RESET) && !$past(CORE_RESET, 2) |=> !PRDATA[4])
      else $error("flag survives brown-out");
   COV_CORE_RESET: cover property ($rose(CORE_RESET));
   COV_UNMAPPED: cover property (PSEL && PENABLE && PSLVERR);
   COV_SHIFTING: cover property ($fell(TDO_OE_N));
endmodule : scan_monitor

bind boundary_scan_chain_logic scan_monitor u_mon (
   .CLOCK(CLOCK), .RST(RST), .BROWN_OUT_RESET(BROWN_OUT_RESET), .TDO_OE_N(TDO_OE_N),
   .TEST_PORT_FUSE(TEST_PORT_FUSE), .CORE_RESET(CORE_RESET), .TEST_RESET_EVENT(TEST_RESET_EVENT),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR)
);

// [tb/jtag_ctl.sv]
// model of the external test controller on the test pins
// assumes CLOCK is the block's clock; one test clock spans eight of them
`timescale 1ns/1ps
module jtag_ctl (
   input  wire logic            CLOCK,
   input  wire logic            TDO,
   input  wire logic            TDO_OE_N,
   output scan_pkg::tap_in_type TAP_IN
);
   logic oe_seen = 1'b0;
   initial TAP_IN = '0;
   // test clock rests low between frames; data out read just before the fall
   task automatic tck_cycle(input logic tms, input logic tdi, output logic tdo);
      @(posedge CLOCK);
      TAP_IN.tms <= tms;
      TAP_IN.tdi <= tdi;
      repeat (3) @(posedge CLOCK);
      TAP_IN.tck <= 1'b1;
      repeat (4) @(posedge CLOCK);
      // a released line reads as the inverse, so a late output enable shows up
      tdo = TDO_OE_N ? ~TDO : TDO;
      if (TDO_OE_N === 1'b0) oe_seen = 1'b1;
      TAP_IN.tck <= 1'b0;
   endtask : tck_cycle
   task automatic tap_reset();
      logic b;
      repeat (5) tck_cycle(1'b1, 1'b0, b);
      tck_cycle(1'b0, 1'b0, b);
   endtask : tap_reset
   // from run-idle through capture and shift, back to run-idle
   task automatic scan(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dout);
      logic b;
      dout = '0;
      tck_cycle(1'b1, 1'b0, b);
      if (ir) tck_cycle(1'b1, 1'b0, b);
      tck_cycle(1'b0, 1'b0, b);
      tck_cycle(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         tck_cycle(i == n - 1, din[i], b);
         dout[i] = b;
      end
      tck_cycle(1'b1, 1'b0, b);
      tck_cycle(1'b0, 1'b0, b);
      TAP_IN.tdi <= ~din[n-1];
   endtask : scan
endmodule : jtag_ctl

// [tb/tb_top.sv]
// self-checking bench for the boundary-scan block
// assumes the controller model and the bound port monitor
`timescale 1ns/1ps
`include "scan_cfg.svh"
module tb_top;
   // ------------------------------
   // signals and instances
   // ------------------------------
   logic                    clock, rst, bor, fuse, lv_n, hv, tdo, tdo_oe_n, core_reset, rst_event;
   logic                    psel, penable, pwrite, pready, pslverr, last_err;
   logic [7:0]              pin_in, paddr;
   logic [4:0]              osc_en, osc_clk;
   logic [31:0]             pwdata, prdata, q;
   logic [63:0]             cap;
   scan_pkg::core_pins_type pins;
   scan_pkg::tap_in_type    tap;
   int                      errors, n_tests;
   boundary_scan_chain_logic dut (
      .CLOCK(clock), .RST(rst), .BROWN_OUT_RESET(bor), .TAP_IN(tap), .TDO(tdo), .TDO_OE_N(tdo_oe_n),
      .TEST_PORT_FUSE(fuse), .PIN_IN(pin_in), .CORE_PINS(pins), .LOW_VOLTAGE_RESET_N(lv_n),
      .HIGH_VOLTAGE_RESET(hv), .OSC_ENABLE(osc_en), .OSC_CLOCK(osc_clk), .CORE_RESET(core_reset),
      .TEST_RESET_EVENT(rst_event), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
   jtag_ctl u_jtag (.CLOCK(clock), .TDO(tdo), .TDO_OE_N(tdo_oe_n), .TAP_IN(tap));
   always #25 clock = ~clock;
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [37:0] expect_chain();
      logic [37:0] e;
      for (int p = 0; p < 8; p++) begin
         e[3*p] = ~pins.global_pullup_disable & ~pins.direction_bit[p] & pins.port_output_bit[p];
         e[3*p+1] = pins.direction_bit[p];
         e[3*p+2] = pin_in[p];
      end
      e[25:24] = pins.two_wire_drive_enable;
      e[27:26] = {hv, ~lv_n};
      for (int o = 0; o < 5; o++) begin
         e[28+2*o] = osc_en[o];
         e[29+2*o] = osc_en[o] ? osc_clk[o] : (o == 3);
      end
      return e;
   endfunction : expect_chain
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_regs();
      apb(1'b0, `ADDR_MCU_CS, 32'h0);
      check("status reset", q, 32'h0);
      apb(1'b1, 8'h38, 32'hFF);
      check("unmapped write err", last_err, 1'b1);
      apb(1'b0, 8'h30, 32'h0);
      check("unmapped read", {last_err, q}, {1'b1, 32'h0});
      $display("regs test done");
   endtask : t_regs
   task automatic t_bypass();
      u_jtag.tap_reset();
      u_jtag.scan(1'b0, 64'h0, 32, cap);
      check("id stream", cap[31:0], `IDCODE_VALUE);
      u_jtag.scan(1'b1, `OP_BYPASS, 4, cap);
      check("ir capture", cap[3:0], 4'h1);
      u_jtag.scan(1'b0, 64'hA5, 8, cap);
      check("bypass stream", cap[7:0], 8'h4A);
      $display("bypass test done");
   endtask : t_bypass
   task automatic t_snapshot();
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         pin_in <= k ? 8'hC3 : 8'h5A;
         pins <= k ? {8'hF0, 8'h55, 1'b1, 2'b01} : {8'h0F, 8'h33, 1'b0, 2'b10};
         lv_n <= k[0];
         hv <= ~k[0];
         osc_en <= k ? 5'h00 : 5'h06;
         osc_clk <= k ? 5'h17 : 5'h1F;
         u_jtag.tap_reset();
         u_jtag.scan(1'b1, `OP_SNAPSHOT, 4, cap);
         // preload keeps two-wire drive and all but one clock source off
         u_jtag.scan(1'b0, 64'h10FFFFFF, 38, cap);
         check("chain capture", cap[37:0], expect_chain());
         check("core idle", core_reset, 1'b0);
      end
      $display("snapshot test done");
   endtask : t_snapshot
   task automatic t_core_reset();
      u_jtag.scan(1'b1, `OP_CORE_RESET, 4, cap);
      u_jtag.scan(1'b0, 64'h1, 1, cap);
      check("core reset on", {core_reset, rst_event}, 2'b11);
      apb(1'b1, `ADDR_MCU_CS, 32'h0);
      apb(1'b0, `ADDR_MCU_CS, 32'h0);
      check("flag set", q[4], 1'b1);
      u_jtag.scan(1'b0, 64'h0, 1, cap);
      check("reset reg kept", {cap[0], core_reset}, 2'b10);
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, `ADDR_MCU_CS, 32'h0);
      check("flag after reset", q[4], 1'b1);
      apb(1'b1, `ADDR_MCU_CS, 32'h0);
      apb(1'b0, `ADDR_MCU_CS, 32'h0);
      check("flag cleared", q[4], 1'b0);
      u_jtag.tap_reset();
      u_jtag.scan(1'b1, `OP_CORE_RESET, 4, cap);
      u_jtag.scan(1'b0, 64'h1, 1, cap);
      u_jtag.scan(1'b0, 64'h0, 1, cap);
      @(posedge clock);
      bor <= 1'b1;
      apb(1'b0, `ADDR_MCU_CS, 32'h0);
      check("flag brown-out", q[4], 1'b0);
      bor <= 1'b0;
      $display("core reset test done");
   endtask : t_core_reset
   task automatic t_disable();
      apb(1'b1, `ADDR_MCU_CS, 32'h80);
      repeat (4) @(posedge clock);
      apb(1'b1, `ADDR_MCU_CS, 32'h80);
      apb(1'b0, `ADDR_MCU_CS, 32'h0);
      check("single write", q[7], 1'b0);
      apb(1'b1, `ADDR_MCU_CS, 32'h80);
      apb(1'b1, `ADDR_MCU_CS, 32'h80);
      apb(1'b0, `ADDR_MCU_CS, 32'h0);
      check("double write", q[7], 1'b1);
      u_jtag.oe_seen = 1'b0;
      u_jtag.scan(1'b1, `OP_BYPASS, 4, cap);
      check("port off", u_jtag.oe_seen, 1'b0);
      apb(1'b1, `ADDR_MCU_CS, 32'h0);
      apb(1'b1, `ADDR_MCU_CS, 32'h0);
      u_jtag.tap_reset();
      u_jtag.scan(1'b1, `OP_BYPASS, 4, cap);
      check("port on", {u_jtag.oe_seen, cap[3:0]}, 5'h11);
      fuse <= 1'b0;
      u_jtag.oe_seen = 1'b0;
      u_jtag.scan(1'b1, `OP_BYPASS, 4, cap);
      check("fuse clear", u_jtag.oe_seen, 1'b0);
      fuse <= 1'b1;
      $display("disable test done");
   endtask : t_disable
   // ------------------------------
   // main sequence and watchdog
   // ------------------------------
   initial begin
      {clock, hv, psel, penable, pwrite, paddr, pwdata, pin_in, osc_en, osc_clk} = '0;
      {rst, bor, fuse, lv_n} = 4'hF;
      pins = '0;
      errors = 0;
      n_tests = 0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      bor <= 1'b0;
      t_regs();
      t_bypass();
      t_snapshot();
      t_core_reset();
      t_disable();
      wrap_up();
   end
   initial begin
      repeat (30000) @(posedge clock);
      errors++;
      $display("unexpected timeout");
      wrap_up();
   end
endmodule : tb_top
